// file: design/board_end.sv
// Baseboard end: reset controller facing the tile site.
// Holds the bus master side idle with constant drives; its user ports are only the reset level select, power good and reset outputs.
module board_end (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    tile_site_if.board       bus,
    input  wire logic [2:0]  reset_level_select_i,
    input  wire logic        power_good_i,
    output logic             system_reset_n_o,
    output logic [2:0]       reset_level_o
);
    logic       req_s1, req_s2;
    logic       done_s1, done_s2;
    logic       por_n, next_por_n;
    logic       sys_n, next_sys_n;
    logic [2:0] level, next_level;

    // Synchronise tile inputs from any clock domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_s1  <= 1'b1;
            req_s2  <= 1'b1;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end else begin
            req_s1  <= bus.soft_reset_request_n;       // [R10]
            req_s2  <= req_s1;
            done_s1 <= bus.config_done;
            done_s2 <= done_s1;
        end
    end

    // Reset sequencing
    always_comb begin
        next_por_n = power_good_i;
        next_sys_n = 1'b1;
        next_level = level;
        if (!done_s2 || !power_good_i) begin
            next_sys_n = 1'b0;                         // [R16]
        end else if (!req_s2) begin
            next_sys_n = 1'b0;                         // [R8]
            next_level = reset_level_select_i;         // [R9]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_n <= 1'b0;
            sys_n <= 1'b0;
            level <= tile_site_pkg::LEVEL_RST;
        end else begin
            por_n <= next_por_n;
            sys_n <= next_sys_n;
            level <= next_level;
        end
    end

    // Bus master idle; host never targets below the tile window
    assign bus.awvalid            = 1'b0;               // [R3]
    assign bus.awaddr             = tile_site_pkg::TILE_BASE; // [R2]
    assign bus.awid               = 4'h0;
    assign bus.awlen              = 8'h00;
    assign bus.wvalid             = 1'b0;
    assign bus.wdata              = tile_site_pkg::DATA_ZERO;
    assign bus.wlast              = 1'b0;
    assign bus.bready             = 1'b1;
    assign bus.arvalid            = 1'b0;
    assign bus.araddr             = tile_site_pkg::TILE_BASE;
    assign bus.arid               = 4'h0;
    assign bus.arlen              = 8'h00;
    assign bus.rready             = 1'b1;
    assign bus.system_reset_out_n = sys_n;
    assign bus.power_on_reset_n   = por_n;
    assign system_reset_n_o       = sys_n;
    assign reset_level_o          = level;
endmodule : board_end

// file: design/default_slave.sv
// Default slave answering every undecoded access with DECERR.
// Assumes one outstanding write and one outstanding read at a time.
module default_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        awvalid_i,
    input  wire logic [31:0] awaddr_i,
    input  wire logic [3:0]  awid_i,
    output logic             awready_o,
    input  wire logic        wvalid_i,
    input  wire logic        wlast_i,
    output logic             wready_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    output logic [3:0]       bid_o,
    input  wire logic        arvalid_i,
    input  wire logic [31:0] araddr_i,
    input  wire logic [3:0]  arid_i,
    input  wire logic [7:0]  arlen_i,
    output logic             arready_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    output logic [3:0]       rid_o,
    output logic             rlast_o,
    output logic [31:0]      err_addr_o,
    output logic             err_write_o,
    output logic [7:0]       err_count_o
);
    typedef enum logic [1:0] {W_ADDR, W_DATA, W_RESP} w_state_t;
    typedef enum logic [0:0] {R_ADDR, R_DATA} r_state_t;

    w_state_t    w_state, next_w_state;
    r_state_t    r_state, next_r_state;
    logic [3:0]  bid, next_bid;
    logic [3:0]  rid, next_rid;
    logic [7:0]  beats, next_beats;
    logic [31:0] err_addr, next_err_addr;
    logic        err_write, next_err_write;
    logic [7:0]  err_count, next_err_count;

    // -------------------------------------------------------------------
    // Write path: accept all beats then one response
    // -------------------------------------------------------------------
    always_comb begin
        next_w_state = w_state;
        next_bid     = bid;
        case (w_state)
            W_ADDR: if (awvalid_i) begin
                next_bid     = awid_i;
                next_w_state = W_DATA;
            end
            W_DATA: if (wvalid_i && wlast_i) begin
                next_w_state = W_RESP;                 // [R6]
            end
            W_RESP: if (bready_i) begin
                next_w_state = W_ADDR;                 // [R18]
            end
            default: next_w_state = W_ADDR;
        endcase
    end

    // -------------------------------------------------------------------
    // Read path: DECERR on every beat, last on the final one
    // -------------------------------------------------------------------
    always_comb begin
        next_r_state = r_state;
        next_rid     = rid;
        next_beats   = beats;
        case (r_state)
            R_ADDR: if (arvalid_i) begin
                next_rid     = arid_i;
                next_beats   = arlen_i;
                next_r_state = R_DATA;
            end
            R_DATA: if (rready_i) begin
                if (beats == 8'h00) begin
                    next_r_state = R_ADDR;             // [R6]
                end else begin
                    next_beats = beats - 8'h01;
                end
            end
            default: next_r_state = R_ADDR;
        endcase
    end

    // Record details of the latest decode error; a write wins over a read accepted in the same cycle
    always_comb begin
        next_err_addr  = err_addr;
        next_err_write = err_write;
        next_err_count = err_count;
        if (w_state == W_ADDR && awvalid_i) begin
            next_err_addr  = awaddr_i;                 // [R5]
            next_err_write = 1'b1;
        end else if (r_state == R_ADDR && arvalid_i) begin
            next_err_addr  = araddr_i;                 // [R5]
            next_err_write = 1'b0;
        end
        if ((w_state == W_ADDR && awvalid_i) ||
            (r_state == R_ADDR && arvalid_i)) begin
            if (err_count != 8'hff) begin
                next_err_count = err_count + 8'h01;
            end
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_state   <= W_ADDR;
            r_state   <= R_ADDR;
            bid       <= 4'h0;
            rid       <= 4'h0;
            beats     <= 8'h00;
            err_addr  <= 32'h0000_0000;
            err_write <= 1'b0;
            err_count <= 8'h00;
        end else begin
            w_state   <= next_w_state;
            r_state   <= next_r_state;
            bid       <= next_bid;
            rid       <= next_rid;
            beats     <= next_beats;
            err_addr  <= next_err_addr;
            err_write <= next_err_write;
            err_count <= next_err_count;
        end
    end

    // Handshake outputs from state
    assign awready_o   = (w_state == W_ADDR);
    assign wready_o    = (w_state == W_DATA);
    assign bvalid_o    = (w_state == W_RESP);
    assign bid_o       = bid;
    assign arready_o   = (r_state == R_ADDR);
    assign rvalid_o    = (r_state == R_DATA);
    assign rid_o       = rid;
    assign rlast_o     = (r_state == R_DATA) && (beats == 8'h00); // [R18]
    assign err_addr_o  = err_addr;
    assign err_write_o = err_write;
    assign err_count_o = err_count;
endmodule : default_slave

// file: design/tile_end.sv
// Tile end: outbound bus responder plus tile-side reset duties.
// Assumes the tile clock comes from the baseboard oscillator.
module tile_end (
    input  wire logic        clk_i,               // [R17]
    input  wire logic        rst_i,
    tile_site_if.tile        bus,
    input  wire logic        configured_i,
    input  wire logic        soft_reset_req_i,
    output logic             debug_test_reset_n_o,
    output logic [31:0]      err_addr_o,
    output logic             err_write_o,
    output logic [7:0]       err_count_o,
    output logic             soft_reset_busy_o
);
    typedef enum logic [1:0] {S_IDLE, S_DRIVE, S_WAIT} srst_state_t;

    logic        sys_n_s1, sys_n_s2;
    logic        por_n_s1, por_n_s2;
    logic        req_s1, req_s2;
    logic        cfg_s1, cfg_s2;
    logic        por_n_prev, next_por_n_prev;
    srst_state_t srst_state, next_srst_state;
    logic [7:0]  srst_cnt, next_srst_cnt;
    logic [7:0]  trst_cnt, next_trst_cnt;
    logic        drive_low, next_drive_low;
    logic        trst_n, next_trst_n;
    logic        done, next_done;
    logic [31:0] ds_addr;
    logic [1:0]  ds_resp;
    logic        ds_rlast;

    // -------------------------------------------------------------------
    // Bus: all accesses land on the default slave; tile window is
    // left for user slaves, so here the whole map answers DECERR
    // -------------------------------------------------------------------
    default_slave u_default (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .awvalid_i  (bus.awvalid),
        .awaddr_i   (bus.awaddr),
        .awid_i     (bus.awid),
        .awready_o  (bus.awready),
        .wvalid_i   (bus.wvalid),
        .wlast_i    (bus.wlast),
        .wready_o   (bus.wready),
        .bvalid_o   (bus.bvalid),
        .bready_i   (bus.bready),
        .bid_o      (bus.bid),
        .arvalid_i  (bus.arvalid),
        .araddr_i   (bus.araddr),
        .arid_i     (bus.arid),
        .arlen_i    (bus.arlen),
        .arready_o  (bus.arready),
        .rvalid_o   (bus.rvalid),
        .rready_i   (bus.rready),
        .rid_o      (bus.rid),
        .rlast_o    (ds_rlast),
        .err_addr_o (ds_addr),
        .err_write_o(err_write_o),
        .err_count_o(err_count_o)
    );

    // Every access, any address, gets an answer
    assign ds_resp    = tile_site_pkg::RESP_DECERR;   // [R1] [R4]
    assign bus.bresp  = ds_resp;
    assign bus.rresp  = ds_resp;                      // [R18]
    assign bus.rdata  = tile_site_pkg::DATA_ZERO;
    assign bus.rlast  = ds_rlast;
    assign err_addr_o = ds_addr;

    // -------------------------------------------------------------------
    // Synchronisers for pins, user request and configured input
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_n_s1 <= 1'b1;
            sys_n_s2 <= 1'b1;
            por_n_s1 <= 1'b0;
            por_n_s2 <= 1'b0;
            req_s1   <= 1'b0;
            req_s2   <= 1'b0;
            cfg_s1   <= 1'b0;
            cfg_s2   <= 1'b0;
        end else begin
            sys_n_s1 <= bus.system_reset_out_n;
            sys_n_s2 <= sys_n_s1;
            por_n_s1 <= bus.power_on_reset_n;
            por_n_s2 <= por_n_s1;
            req_s1   <= soft_reset_req_i;
            req_s2   <= req_s1;
            cfg_s1   <= configured_i;
            cfg_s2   <= cfg_s1;
        end
    end

    // -------------------------------------------------------------------
    // Soft reset request: hold low a minimum time, release on sys reset
    // -------------------------------------------------------------------
    always_comb begin
        next_srst_state = srst_state;
        next_srst_cnt   = srst_cnt;
        next_drive_low  = drive_low;
        case (srst_state)
            S_IDLE: if (req_s2 && sys_n_s2) begin
                next_drive_low  = 1'b1;                // [R8] [R13]
                next_srst_cnt   = 8'h00;
                next_srst_state = S_DRIVE;
            end
            S_DRIVE: begin
                if (srst_cnt < 8'(tile_site_pkg::SRST_MIN_CYC)) begin
                    next_srst_cnt = srst_cnt + 8'h01;  // [R11]
                end else if (!sys_n_s2) begin
                    next_drive_low  = 1'b0;            // [R12]
                    next_srst_state = S_WAIT;
                end
            end
            S_WAIT: if (sys_n_s2 && !req_s2) begin
                next_srst_state = S_IDLE;
            end
            default: begin
                next_drive_low  = 1'b0;
                next_srst_state = S_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // Debug test reset pulse from power-on reset, plus the config done register
    // -------------------------------------------------------------------
    always_comb begin
        next_por_n_prev = por_n_s2;
        next_trst_cnt   = trst_cnt;
        next_trst_n     = trst_n;
        next_done       = cfg_s2;                      // [R15]
        if (!por_n_s2 || (por_n_s2 && !por_n_prev)) begin
            next_trst_n   = 1'b0;                      // [R14]
            next_trst_cnt = 8'h00;
        end else if (!trst_n) begin
            if (trst_cnt < 8'(tile_site_pkg::TRST_PULSE_CYC - 1)) begin
                next_trst_cnt = trst_cnt + 8'h01;
            end else begin
                next_trst_n = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst_state <= S_IDLE;
            srst_cnt   <= 8'h00;
            drive_low  <= 1'b0;
            por_n_prev <= 1'b0;
            trst_cnt   <= 8'h00;
            trst_n     <= 1'b0;
            done       <= 1'b0;
        end else begin
            srst_state <= next_srst_state;
            srst_cnt   <= next_srst_cnt;
            drive_low  <= next_drive_low;
            por_n_prev <= next_por_n_prev;
            trst_cnt   <= next_trst_cnt;
            trst_n     <= next_trst_n;
            done       <= next_done;
        end
    end

    // Pin drivers: request line by enable only, never driven high
    assign bus.soft_reset_request_n_oe = drive_low;   // [R13]
    assign bus.config_done             = done;
    assign debug_test_reset_n_o        = trst_n;
    assign soft_reset_busy_o           = (srst_state != S_IDLE);
endmodule : tile_end

// file: design/tile_site_if.sv
// Interface joining the tile end and the baseboard end.
// The interface resolves the open-drain request wire from the enable.
interface tile_site_if (
    input wire logic clk_i,
    input wire logic rst_i
);
    // Outbound multiplexed bus, simplified to its address, data and response channels
    logic        awvalid;
    logic        awready;
    logic [31:0] awaddr;
    logic [3:0]  awid;
    logic [7:0]  awlen;
    logic        wvalid;
    logic        wready;
    logic [31:0] wdata;
    logic        wlast;
    logic        bvalid;
    logic        bready;
    logic [1:0]  bresp;
    logic [3:0]  bid;
    logic        arvalid;
    logic        arready;
    logic [31:0] araddr;
    logic [3:0]  arid;
    logic [7:0]  arlen;
    logic        rvalid;
    logic        rready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  rid;
    logic        rlast;
    // Reset signals
    logic        soft_reset_request_n_oe;
    logic        soft_reset_request_n;
    logic        system_reset_out_n;
    logic        power_on_reset_n;
    logic        config_done;

    // Open-drain wire level, pulled high when released
    assign soft_reset_request_n = !soft_reset_request_n_oe;

    modport tile (
        input  awvalid, awaddr, awid, awlen, wvalid, wdata, wlast, bready,
        input  arvalid, araddr, arid, arlen, rready,
        output awready, wready, bvalid, bresp, bid,
        output arready, rvalid, rdata, rresp, rid, rlast,
        output soft_reset_request_n_oe, config_done,
        input  soft_reset_request_n, system_reset_out_n, power_on_reset_n
    );

    modport board (
        output awvalid, awaddr, awid, awlen, wvalid, wdata, wlast, bready,
        output arvalid, araddr, arid, arlen, rready,
        input  awready, wready, bvalid, bresp, bid,
        input  arready, rvalid, rdata, rresp, rid, rlast,
        input  soft_reset_request_n, config_done,
        output system_reset_out_n, power_on_reset_n
    );
endinterface : tile_site_if

// file: design/tile_site_pkg.sv
// Package of shared constants for the tile site decode and reset pair.
// Assumes a single 100 MHz clock on both ends and a synchronous reset.
//
// Functional notes
// [R1] Tile answers every outbound bus transaction
// [R2] Top gigabyte routed to tile slaves; here tile_end sends it, like every other address, to the default slave
// [R3] Bridge never issues addresses below top gigabyte
// [R4] Undecoded access goes to DECERR default slave
// [R5] Default slave records last decode error details
// [R6] DECERR still completes every data beat
// [R7] Only outbound slaves, only inbound masters connected
// [R8] Tile pulls soft reset line to reset
// [R9] Controller enters selected reset level on request
// [R10] Controller synchronises soft reset request
// [R11] Request held at least two sampling periods
// [R12] Release request once system reset asserts
// [R13] Open-drain line: drive low or release
// [R14] Debug test reset pulse from power-on reset
// [R15] Configuration done low until configured
// [R16] System held in reset while done low
// [R17] Tile uses two clocks from oscillator two; here tile_end runs on the one clock clk_i
// [R18] One write DECERR, read DECERR per beat
package tile_site_pkg;

    // -------------------------------------------------------------------
    // Bus geometry
    // -------------------------------------------------------------------
    localparam int          ADDR_W      = 32;
    localparam int          DATA_W      = 32;
    localparam int          ID_W        = 4;
    localparam int          LEN_W       = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;
    localparam logic [31:0] TILE_BASE   = 32'hc000_0000;
    localparam logic [31:0] TILE_MASK   = 32'hc000_0000;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

    // -------------------------------------------------------------------
    // Reset timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SRST_MIN_NS      = 84;
    localparam int SRST_MIN_CYC     =
        (SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRST_PULSE_NS    = 100;
    localparam int TRST_PULSE_CYC   = TRST_PULSE_NS / CLK_PERIOD_NS;
    localparam int CNT_W            = 8;
    localparam logic [2:0] LEVEL_RST = 3'h0;

    // Tile decode: true when address falls in the tile window
    function automatic logic in_tile(input logic [31:0] addr);
        in_tile = (addr & TILE_MASK) == TILE_BASE;
    endfunction : in_tile

endpackage : tile_site_pkg

// file: test/test_tile_site_axi_decode_and_reset.sv
// Bench: tile and board ends joined, plus a bench-driven tile end.
// Assumes the design files are compiled first.
module test_tile_site_axi_decode_and_reset;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        cfg_a = 0, req_a = 0, cfg_b = 0, req_b = 0, pg = 0;
    logic [2:0]  lvl = 3'h0, lvl_o;
    logic        trst_a, trst_b, busy_a, busy_b, sysn, ew, lw;
    logic [31:0] ea, la;
    logic [7:0]  ec;
    int          failures = 0, checked = 0, nerr = 0, k;
    logic [5:0]  bq[$];
    logic [6:0]  rq[$];
    logic [31:0] at[4] = '{32'hbfff_fffc, 32'hc000_0000, 32'h0, 32'hffff_fffc};

    always #5 clk_i = ~clk_i;
    tile_site_if ia (.clk_i(clk_i), .rst_i(rst_i));
    tile_site_if ib (.clk_i(clk_i), .rst_i(rst_i));
    tile_end i_tile_end (.clk_i(clk_i), .rst_i(rst_i), .bus(ia),
        .configured_i(cfg_a), .soft_reset_req_i(req_a),
        .debug_test_reset_n_o(trst_a), .err_addr_o(), .err_write_o(),
        .err_count_o(), .soft_reset_busy_o(busy_a));
    board_end i_board_end (.clk_i(clk_i), .rst_i(rst_i), .bus(ia),
        .reset_level_select_i(lvl), .power_good_i(pg),
        .system_reset_n_o(sysn), .reset_level_o(lvl_o));
    tile_end i_tile_end_b (.clk_i(clk_i), .rst_i(rst_i), .bus(ib),
        .configured_i(cfg_b), .soft_reset_req_i(req_b),
        .debug_test_reset_n_o(trst_b), .err_addr_o(ea), .err_write_o(ew),
        .err_count_o(ec), .soft_reset_busy_o(busy_b));
    tile_site_checker i_tile_site_checker (.clk_i(clk_i), .rst_i(rst_i),
        .soft_reset_request_n_oe(ia.soft_reset_request_n_oe),
        .soft_reset_request_n(ia.soft_reset_request_n),
        .system_reset_out_n(ia.system_reset_out_n),
        .config_done(ia.config_done), .arvalid(ib.arvalid),
        .arready(ib.arready), .rvalid(ib.rvalid), .rready(ib.rready),
        .rresp(ib.rresp), .bvalid(ib.bvalid), .bresp(ib.bresp));

    // ------------------------------------------------------------------
    // Compare tasks and verdict
    // ------------------------------------------------------------------
    task check_val(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : check_val
    task check_b(logic [5:0] e, logic [5:0] g);
        check_val("bid_bresp", {26'h0, e}, {26'h0, g});
    endtask : check_b
    task check_r(logic [6:0] e, logic [6:0] g);
        check_val("rid_rresp_rlast", {25'h0, e}, {25'h0, g});
    endtask : check_r
    task print_verdict();
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Response monitor takes the oldest note
    always @(posedge clk_i) begin
        if (ib.bvalid === 1'b1 && ib.bready === 1'b1)
            check_b(bq.pop_front(), {ib.bid, ib.bresp});
        if (ib.rvalid === 1'b1 && ib.rready === 1'b1)
            check_r(rq.pop_front(), {ib.rid, ib.rresp, ib.rlast});
    end
    // Far side stalls at random
    always @(negedge clk_i) begin
        ib.bready <= 1'($urandom);
        ib.rready <= 1'($urandom);
    end

    // ------------------------------------------------------------------
    // Bus drivers
    // ------------------------------------------------------------------
    task wr(logic [31:0] a, logic [3:0] id, logic [7:0] n);
        bq.push_back({id, tile_site_pkg::RESP_DECERR});
        ib.awaddr = a; ib.awid = id; ib.awlen = n; ib.awvalid = 1;
        #1 while (ib.awready !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        ib.awvalid = 0;
        for (int i = 0; i <= n; i++) begin
            ib.wdata = $urandom; ib.wlast = (i == n); ib.wvalid = 1;
            #1 while (ib.wready !== 1'b1) @(negedge clk_i);
            @(negedge clk_i);
        end
        ib.wvalid = 0; ib.wlast = 0;
        nerr++; la = a; lw = 1;
    endtask : wr
    task rd(logic [31:0] a, logic [3:0] id, logic [7:0] n);
        for (int i = 0; i <= n; i++)
            rq.push_back({id, tile_site_pkg::RESP_DECERR, i == n});
        ib.araddr = a; ib.arid = id; ib.arlen = n; ib.arvalid = 1;
        #1 while (ib.arready !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        ib.arvalid = 0;
        nerr++; la = a; lw = 0;
    endtask : rd

    // Watchdog
    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        $urandom(32'h70849782);
        {ib.awvalid, ib.wvalid, ib.arvalid, ib.wlast} = 4'h0;
        {ib.awaddr, ib.araddr, ib.wdata} = '0;
        {ib.awid, ib.arid, ib.awlen, ib.arlen} = '0;
        ib.power_on_reset_n = 0; ib.system_reset_out_n = 0;
        repeat (16) @(negedge clk_i);
        rst_i = 0;
        repeat (20) @(negedge clk_i);
        check_val("sys_rst", 0, sysn);
        check_val("trst_a", 0, trst_a);
        check_val("trst_b", 0, trst_b);
        check_val("done_b", 0, ib.config_done);
        pg = 1; cfg_a = 1; cfg_b = 1; ib.power_on_reset_n = 1;
        for (k = 0; k < 30 && trst_b !== 1'b1; k++) @(negedge clk_i);
        check_val("trst_len", 1, k >= tile_site_pkg::TRST_PULSE_CYC
            && k <= tile_site_pkg::TRST_PULSE_CYC + 3);
        for (k = 0; k < 200 && sysn !== 1'b1; k++) @(negedge clk_i);
        check_val("sys_run", 1, sysn);
        check_val("done_b", 1, ib.config_done);
        lvl = 3'($urandom); req_a = 1;
        repeat (3) @(negedge clk_i);
        req_a = 0;
        for (k = 0; k < 100 && sysn !== 1'b0; k++) @(negedge clk_i);
        check_val("level", lvl, lvl_o);
        for (k = 0; k < 300 && busy_a !== 1'b0; k++) @(negedge clk_i);
        check_val("busy_a", 0, busy_a);
        ib.system_reset_out_n = 1; req_b = 1;
        repeat (3) @(negedge clk_i);
        req_b = 0;
        repeat (30) @(negedge clk_i);
        check_val("oe_hold", 1, ib.soft_reset_request_n_oe);
        check_val("line_low", 0, ib.soft_reset_request_n);
        ib.system_reset_out_n = 0;
        repeat (5) @(negedge clk_i);
        check_val("oe_rel", 0, ib.soft_reset_request_n_oe);
        check_val("line_rel", 1, ib.soft_reset_request_n);
        ib.system_reset_out_n = 1;
        for (int i = 0; i < 24; i++) begin
            la = i < 4 ? at[i] : $urandom;
            if (i % 2 == 1) rd(la, 4'($urandom), 8'($urandom % 4));
            else wr(la, 4'($urandom), 8'($urandom % 4));
        end
        for (k = 0; k < 200 && (bq.size() || rq.size()); k++)
            @(negedge clk_i);
        check_val("drained", 0, bq.size() + rq.size());
        check_val("err_count", nerr, ec);
        check_val("err_addr", la, ea);
        check_val("err_write", lw, ew);
        check_val("busy_b", 0, busy_b);
        print_verdict();
    end
endmodule : test_tile_site_axi_decode_and_reset

// file: test/tile_site_checker.sv
// Checker for the interface joining the tile end and the board end.
// Assumes plain connection to the interface signals, one clock.
module tile_site_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       soft_reset_request_n_oe,
    input wire logic       soft_reset_request_n,
    input wire logic       system_reset_out_n,
    input wire logic       config_done,
    input wire logic       arvalid,
    input wire logic       arready,
    input wire logic       rvalid,
    input wire logic       rready,
    input wire logic [1:0] rresp,
    input wire logic       bvalid,
    input wire logic [1:0] bresp
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Reset duties
    // ------------------------------------------------------------------
    property p_od;
        soft_reset_request_n_oe |-> !soft_reset_request_n;
    endproperty
    a_od: assert property (p_od) else $error("line not low");
    property p_hold;
        $rose(soft_reset_request_n_oe) |->
            soft_reset_request_n_oe [*8] ##1 soft_reset_request_n_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("request short");
    property p_rel;
        !system_reset_out_n [*8] |-> ##[0:4] !soft_reset_request_n_oe;
    endproperty
    a_rel: assert property (p_rel) else $error("request kept");
    property p_req;
        $fell(soft_reset_request_n) |-> ##[0:16] !system_reset_out_n;
    endproperty
    a_req: assert property (p_req) else $error("no reset");
    property p_done;
        !config_done [*3] |-> !system_reset_out_n;
    endproperty
    a_done: assert property (p_done) else $error("reset left");
    property p_cfg;
        config_done |=> config_done;
    endproperty
    a_cfg: assert property (p_cfg) else $error("done dropped");

    // ------------------------------------------------------------------
    // Outbound bus answers
    // ------------------------------------------------------------------
    property p_rd;
        arvalid && arready |-> ##[1:3] rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("no read answer");
    property p_rresp;
        rvalid |-> rresp == tile_site_pkg::RESP_DECERR;
    endproperty
    a_rresp: assert property (p_rresp) else $error("read resp");
    property p_bresp;
        bvalid |-> bresp == tile_site_pkg::RESP_DECERR;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write resp");
    property p_rstand;
        rvalid && !rready |=> rvalid;
    endproperty
    a_rstand: assert property (p_rstand) else $error("beat lost");
endmodule : tile_site_checker
